// ==== rtl/acrc_defines.vh ====
// register offsets, field positions and reset values for the clock rate block
`ifndef ACRC_DEFINES_VH
`define ACRC_DEFINES_VH
`define ACRC_ADDR_W          8
`define ACRC_OFF_BCK_DIV     8'h20
`define ACRC_OFF_FRAME_DIV   8'h21
`define ACRC_OFF_INTERP_SPD  8'h22
`define ACRC_OFF_CYC_HI      8'h23
`define ACRC_OFF_CYC_LO      8'h24
`define ACRC_OFF_AUTO_CTRL   8'h25
`define ACRC_BIT_INTERP      4
`define ACRC_BIT_AUTO_DIS    1
`define ACRC_RST_FRAME_DIV   8'h00
`define ACRC_RST_BCK_DIV     7'h00
`define ACRC_RST_INTERP      1'b0
`define ACRC_RST_SPEED       2'h0
`define ACRC_RST_CYC_HI      8'h01
`define ACRC_RST_CYC_LO      8'h00
`define ACRC_RST_AUTO_DIS    1'b0
`define ACRC_AUTO_SPEED      2'h0
`define ACRC_AUTO_CYCLES     16'h0100
`endif

// ==== rtl/acrc_clk_div.v ====
// programmable clock divider producing a one-cycle tick every div+1 inputs
`timescale 1ns/100ps
module acrc_clk_div #(
	parameter W = 8
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_n,
	input  wire         clk_en,
	// control
	input  wire         run,
	input  wire         in_tick,
	input  wire [W-1:0] div,
	// output
	output reg          out_tick,
	output reg          out_level
);
	reg [W-1:0] cnt_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q     <= {W{1'b0}};
			out_tick  <= 1'b0;
			out_level <= 1'b0;
		end else if (clk_en) begin
			out_tick <= 1'b0;
			if (!run) begin
				cnt_q     <= {W{1'b0}};
				out_level <= 1'b0;
			end else if (in_tick) begin
				// count reaches div, so period is div + 1 inputs
				if (cnt_q >= div) begin
					cnt_q     <= {W{1'b0}};
					out_tick  <= 1'b1;
					out_level <= ~out_level;
				end else begin
					cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// ==== rtl/acrc_top.v ====
// audio clock rate configuration: registers, dividers and effective settings
// Summary of operation
// - master frame clock equals bit clock divided by field plus one; resets 0
// - interpolation select: 0 gives 8x, 1 gives 16x; resets to 8x
// - two-bit speed band: single, double, quad, octal; resets single
// - automatic clock setting overrides the programmed speed band
// - cycles-per-frame upper byte in its own register, resets to 01
// - cycles-per-frame lower byte separate, resets 00, total 256
// - automatic clock setting overrides the programmed cycles-per-frame
// - automatic setting active after reset; disable bit set selects manual
// - master bit clock is system clock divided by two times (seven-bit field plus one)
`timescale 1ns/100ps
`include "acrc_defines.vh"
module acrc_top (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	input  wire       clk_en,
	// register port
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	output reg        reg_ack,
	// clock mode
	input  wire       master_mode,
	// effective settings toward the audio path
	output reg        interp_ratio_sel,
	output reg  [1:0] speed_band,
	output reg [15:0] frame_cycle_count,
	output reg        auto_clock_active,
	// master mode clocks
	output wire       master_bitclock,
	output wire       frame_clock,
	output wire       frame_tick
);
	reg        rst_s1_q;
	reg        rst_s2_q;
	wire       rst_i_n;
	reg  [7:0] frame_clock_div_q;
	reg  [6:0] master_bitclock_div_q;
	reg        interp_q;
	reg  [1:0] speed_q;
	reg  [7:0] frame_cycles_hi_q;
	reg  [7:0] frame_cycles_lo_q;
	reg        auto_dis_q;
	reg  [7:0] rdata_d;
	wire       bck_tick;
	wire       wr_en;
	wire       rd_en;
	wire       wr_frame_div;
	wire       wr_bck_div;
	wire       wr_interp_spd;
	wire       wr_cyc_hi;
	wire       wr_cyc_lo;
	wire       wr_auto_ctrl;
	reg        interp_d;
	reg  [1:0] speed_band_d;
	reg [15:0] frame_cycles_d;
	reg        auto_active_d;

	// one strobe per register; a low clock enable blocks every write
	assign wr_en         = clk_en & reg_wr;
	assign rd_en         = clk_en & reg_rd;
	assign wr_frame_div  = wr_en & (reg_addr == `ACRC_OFF_FRAME_DIV);
	assign wr_bck_div    = wr_en & (reg_addr == `ACRC_OFF_BCK_DIV);
	assign wr_interp_spd = wr_en & (reg_addr == `ACRC_OFF_INTERP_SPD);
	assign wr_cyc_hi     = wr_en & (reg_addr == `ACRC_OFF_CYC_HI);
	assign wr_cyc_lo     = wr_en & (reg_addr == `ACRC_OFF_CYC_LO);
	assign wr_auto_ctrl  = wr_en & (reg_addr == `ACRC_OFF_AUTO_CTRL);

	// reset released through two flops so removal is synchronous
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_i_n = rst_s2_q;

	// frame clock divider; all eight bits are live
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			frame_clock_div_q <= `ACRC_RST_FRAME_DIV;
		end else if (wr_frame_div) begin
			frame_clock_div_q <= reg_wdata;
		end
	end

	// bit clock divider; the top bit is reserved and dropped
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			master_bitclock_div_q <= `ACRC_RST_BCK_DIV;
		end else if (wr_bck_div) begin
			master_bitclock_div_q <= reg_wdata[6:0];
		end
	end

	// interpolation and speed band share one register; other bits dropped
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			interp_q <= `ACRC_RST_INTERP;
			speed_q  <= `ACRC_RST_SPEED;
		end else if (wr_interp_spd) begin
			interp_q <= reg_wdata[`ACRC_BIT_INTERP];
			speed_q  <= reg_wdata[1:0];
		end
	end

	// bytes are written one at a time, so a count spanning both bytes
	// is briefly mixed while software updates it
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			frame_cycles_hi_q <= `ACRC_RST_CYC_HI;
		end else if (wr_cyc_hi) begin
			frame_cycles_hi_q <= reg_wdata;
		end
	end

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			frame_cycles_lo_q <= `ACRC_RST_CYC_LO;
		end else if (wr_cyc_lo) begin
			frame_cycles_lo_q <= reg_wdata;
		end
	end

	// auto setting disable; the other bits of this register are not built
	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			auto_dis_q <= `ACRC_RST_AUTO_DIS;
		end else if (wr_auto_ctrl) begin
			auto_dis_q <= reg_wdata[`ACRC_BIT_AUTO_DIS];
		end
	end

	// read mux; reserved positions come back as zero
	always @* begin
		case (reg_addr)
		`ACRC_OFF_FRAME_DIV:  rdata_d = frame_clock_div_q;
		`ACRC_OFF_BCK_DIV:    rdata_d = {1'b0, master_bitclock_div_q};
		`ACRC_OFF_INTERP_SPD: rdata_d = {3'h0, interp_q, 2'h0, speed_q};
		`ACRC_OFF_CYC_HI:     rdata_d = frame_cycles_hi_q;
		`ACRC_OFF_CYC_LO:     rdata_d = frame_cycles_lo_q;
		`ACRC_OFF_AUTO_CTRL:  rdata_d = {6'h00, auto_dis_q, 1'b0};
		default:              rdata_d = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			reg_rdata <= 8'h00;
			reg_ack   <= 1'b0;
		end else if (clk_en) begin
			// every access is acked, mapped or not, so a master never hangs
			reg_ack <= rd_en | wr_en;
			if (rd_en) begin
				reg_rdata <= rdata_d;
			end
		end
	end

	// next effective settings; auto mode substitutes fixed defaults because
	// the rate detector lives outside this block
	always @* begin
		interp_d       = interp_q;
		auto_active_d  = ~auto_dis_q;
		speed_band_d   = `ACRC_AUTO_SPEED;
		frame_cycles_d = `ACRC_AUTO_CYCLES;
		if (auto_dis_q) begin
			speed_band_d   = speed_q;
			frame_cycles_d = {frame_cycles_hi_q,
				frame_cycles_lo_q};
		end
	end

	always @(posedge clk or negedge rst_i_n) begin
		if (!rst_i_n) begin
			interp_ratio_sel  <= `ACRC_RST_INTERP;
			speed_band        <= `ACRC_RST_SPEED;
			frame_cycle_count <= `ACRC_AUTO_CYCLES;
			auto_clock_active <= 1'b1;
		end else if (clk_en) begin
			interp_ratio_sel  <= interp_d;
			speed_band        <= speed_band_d;
			frame_cycle_count <= frame_cycles_d;
			auto_clock_active <= auto_active_d;
		end
	end

	// bit clock from system clock, then frame clock from bit clock
	// level outputs toggle once per tick, so they run at half the tick rate
	acrc_clk_div #(
		.W (7)
	) u_bck_div (
		.clk       (clk),
		.rst_n     (rst_i_n),
		.clk_en    (clk_en),
		.run       (master_mode),
		.in_tick   (1'b1),
		.div       (master_bitclock_div_q),
		.out_tick  (bck_tick),
		.out_level (master_bitclock)
	);

	acrc_clk_div #(
		.W (8)
	) u_frame_div (
		.clk       (clk),
		.rst_n     (rst_i_n),
		.clk_en    (clk_en),
		.run       (master_mode),
		.in_tick   (bck_tick),
		.div       (frame_clock_div_q),
		.out_tick  (frame_tick),
		.out_level (frame_clock)
	);
endmodule

// ==== sim/acrc_properties.sv ====
// checker of the clock rate block
`timescale 1ns/100ps
module acrc_properties (
	// clock and register port
	input logic       clk,
	input logic       rst_n,
	input logic       clk_en,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic [7:0] reg_rdata,
	input logic       reg_ack,
	// settings
	input logic       interp_ratio_sel,
	input logic [1:0] speed_band,
	input logic       auto_clock_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire rd = clk_en && reg_rd;
	wire req = rd || clk_en && reg_wr;
	wire w22 = clk_en && reg_wr && reg_addr == 8'h22;
	wire aut = auto_clock_active;
	a_ack_req: assert property (req |=> reg_ack) else $error("no ack");
	a_ack_idle: assert property (clk_en && !reg_rd && !reg_wr |=> !reg_ack)
		else $error("stray ack");
	a_rdata_hold: assert property (!rd |=> $stable(reg_rdata)) else $error("rd");
	a_interp_wr: assert property (w22 |-> ##2
		interp_ratio_sel == $past(reg_wdata[4], 2)) else $error("interp");
	a_band_wr: assert property (w22 && !aut |-> ##2
		speed_band == $past(reg_wdata[1:0], 2)) else $error("band");
	a_auto_band: assert property (aut && $past(aut) |-> !speed_band)
		else $error("auto band");
	a_unmapped_zero: assert property (rd && (reg_addr < 8'h20 ||
		reg_addr > 8'h25) |=> !reg_rdata) else $error("unmapped");
	a_rsv_zero: assert property (rd && reg_addr == 8'h22 |=>
		!(reg_rdata & 8'hEC)) else $error("reserved");
	cover property (w22);
	cover property (rd);
	cover property ($fell(aut));
	cover property (!clk_en && $past(clk_en));
endmodule
bind acrc_top acrc_properties i_props (
	.clk               (clk),
	.rst_n             (rst_n),
	.clk_en            (clk_en),
	.reg_wr            (reg_wr),
	.reg_rd            (reg_rd),
	.reg_addr          (reg_addr),
	.reg_wdata         (reg_wdata),
	.reg_rdata         (reg_rdata),
	.reg_ack           (reg_ack),
	.interp_ratio_sel  (interp_ratio_sel),
	.speed_band        (speed_band),
	.auto_clock_active (auto_clock_active)
);

// ==== sim/testbench.sv ====
// bench of the clock rate block
`timescale 1ns/100ps
module testbench;
	logic        clk = 0, rst_n = 0, clk_en = 1, master_mode = 0;
	logic        reg_wr = 0, reg_rd = 0;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, hi, lo;
	logic [15:0] d, f, rt[7] = '{'h2000, 'h2100, 'h2200, 'h2301, 'h2400,
		'h2500, 'h3000};
	logic        b, fc;
	logic [8:0]  q[$], e;
	wire  [7:0]  reg_rdata;
	wire  [1:0]  speed_band;
	wire  [15:0] frame_cycle_count;
	wire         reg_ack, interp_ratio_sel, auto_clock_active;
	wire         master_bitclock, frame_clock, frame_tick;
	int          err_count = 0, comparisons = 0, n, i, t;
	always #2 clk = ~clk;
	acrc_top i_dut (
		.clk               (clk),
		.rst_n             (rst_n),
		.clk_en            (clk_en),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_rdata         (reg_rdata),
		.reg_ack           (reg_ack),
		.master_mode       (master_mode),
		.interp_ratio_sel  (interp_ratio_sel),
		.speed_band        (speed_band),
		.frame_cycle_count (frame_cycle_count),
		.auto_clock_active (auto_clock_active),
		.master_bitclock   (master_bitclock),
		.frame_clock       (frame_clock),
		.frame_tick        (frame_tick)
	);
	task chk(string s, logic [15:0] x, y);
		comparisons++;
		if (x !== y) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", s, x, y);
		end
	endtask
	task print_verdict;
		if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// bit 8 of a note marks a read
	task acc(bit w, logic [7:0] a, v);
		@(negedge clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, v};
		q.push_back({!w, v});
		@(negedge clk);
		{reg_wr, reg_rd} = 2'h0;
		repeat (2) @(negedge clk);
	endtask
	always @(negedge clk) if (reg_ack === 1'b1) begin
		e = q.pop_front();
		if (e[8]) chk("rdata", e[7:0], reg_rdata);
	end
	// waits for the next frame tick, counting cycles and bit clock toggles
	task wt;
		n = 0;
		t = 0;
		do begin
			b = master_bitclock;
			@(negedge clk);
			t += (master_bitclock !== b);
			n++;
		end while (n < 3000 && frame_tick !== 1'b1);
	endtask
	initial begin
		void'($urandom(10836));
		repeat (5) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		foreach (rt[k]) acc(0, rt[k][15:8], rt[k][7:0]);
		{hi, lo} = 16'($urandom);
		acc(1, 8'h22, 8'hFF);
		chk("interp", 1, interp_ratio_sel);
		chk("band", 0, speed_band);
		chk("auto", 1, auto_clock_active);
		acc(1, 8'h23, hi);
		acc(1, 8'h24, lo);
		acc(0, 8'h22, 8'h13);
		chk("cnt", 'h100, frame_cycle_count);
		acc(1, 8'h25, 8'hFF);
		acc(0, 8'h25, 8'h02);
		chk("auto", 0, auto_clock_active);
		chk("cnt", {hi, lo}, frame_cycle_count);
		for (i = 0; i < 4; i++) begin
			acc(1, 8'h22, 8'(i));
			chk("band", 16'(i), speed_band);
		end
		chk("interp", 0, interp_ratio_sel);
		master_mode = 1;
		for (i = 0; i < 3; i++) begin
			d = 16'($urandom % 4);
			f = i == 2 ? 'hFF : 16'($urandom % 6);
			acc(1, 8'h20, 8'h80 | d[7:0]);
			acc(0, 8'h20, d[7:0]);
			acc(1, 8'h21, f[7:0]);
			repeat (2) wt;
			fc = frame_clock;
			wt;
			chk("period", (d + 1) * (f + 1), 16'(n));
			chk("bclk", f + 1, 16'(t));
			chk("fclk", !fc, frame_clock);
		end
		// a low clock enable must hold the bit clock divider still
		clk_en = 0;
		t = 0;
		repeat (16) begin
			b = master_bitclock;
			@(negedge clk);
			t += (master_bitclock !== b);
		end
		chk("freeze", 0, 16'(t));
		clk_en = 1;
		print_verdict;
	end
	initial begin
		#100000;
		err_count++;
		print_verdict;
	end
endmodule
